// ### serial_map.vh
`ifndef SERIAL_MAP_VH
`define SERIAL_MAP_VH
// Summary of operation
// R1: Fast reference: rate is reference over sixteen-divisor
// R2: Slow reference: rate is 7.3728 MHz over sixty-four-divisor
// R3: Slow reference: 230.4k only as standard selection
// R4: Current loop fitted: highest rate is 19200
// R5: Three fixed profiles or per-line special profile
// R6: Hardware profile: RTS flow, DTR connection, CTS gates
// R7: Software profile: 0x11/0x13 control, filtered both ways
// R8: Software profile: RTS, DTR high; CTS, DSR ignored
// R9: Control character filters separately per direction
// R10: Hold received bytes programmed 10 ms ticks
// R11: Clear-on-connect empties serial buffer on connect
// R12: Clear-on-connect off keeps data across connections
// R13: Settings apply on save; save empties buffers
// R14: Factory default restores, closes session, resets
// R15: RTS flow: high while accepting, low at limit; code drops RTS at HI_LEVEL, RTS_MARGIN bytes below BUF_LIMIT
// R16: CTS flow: send only while CTS high; code sends XON/XOFF regardless of CTS when XON transmit is on
// R17: DTR connection: high while connection exists
// R18: Delay restarts per byte; flush on expiry/full
// R19: Control codes compared at configured width

// Register byte offsets
`define A_CONFIG  8'h00
`define A_DIVISOR 8'h04
`define A_SPECIAL 8'h08
`define A_DELAY   8'h0C
`define A_COMMAND 8'h10
`define A_STATUS  8'h14

// Config fields
`define C_PROF_LO  0
`define C_PROF_HI  1
`define C_FLUSH    2
`define C_DATA7    3
`define C_STD230   4
`define CFG_RESET  5'h04

// Special profile fields
`define S_RTS_LO   0
`define S_DTR_LO   2
`define S_CTS_FLOW 4
`define S_XON_RX   5
`define S_XON_TX   6
`define S_FILT_TX  7
`define S_FILT_RX  8
`define SPC_RESET  9'h011

// Command bits
`define CMD_SAVE    0
`define CMD_FACTORY 1

// Profiles and line functions
`define PROF_NONE 2'h0
`define PROF_HW   2'h1
`define PROF_SW   2'h2
`define PROF_SPC  2'h3
`define FN_FLOW   2'h0
`define FN_CONN   2'h1
`define FN_HIGH   2'h2
`define FN_LOW    2'h3

// Control characters
`define CH_XON  8'h11
`define CH_XOFF 8'h13

// Clock and bit-rate references
`define CLK_HZ      64'h0000_0000_05F5_E100
`define REF_FAST_HZ 32'h00A8_C000
`define REF_SLOW_HZ 32'h0070_8000
`define INC_FAST    (({`REF_FAST_HZ, 32'h0000_0000}) / `CLK_HZ)
`define INC_SLOW    (({`REF_SLOW_HZ, 32'h0000_0000}) / `CLK_HZ)
`define SLOW_MUL    18'h0_0004
`define STD230_PRE  18'h0_0002
`define DIV_MIN_F   16'h0003
`define DIV_MIN_S   16'h0001
`define DIV_LOOP_F  16'h0024
`define DIV_LOOP_S  16'h0006
`define DIV_RST_F   16'h0048
`define DIV_RST_S   16'h000C

// Packing delay tick
`define TICK_MS     32'h0000_000A
// 100 MHz cycles in one 10 ms tick
`define TICK_CYCLES 32'h000F_4240
`endif

// ### serial_tick_gen.v
`timescale 1ns/100ps
`include "serial_map.vh"
module serial_tick_gen #(
	parameter PRE_W = 18
) (
	input  wire             clock,    // System clock
	input  wire             rst_n,    // Async reset
	input  wire [31:0]      inc,      // Reference phase step
	input  wire [PRE_W-1:0] prescale, // Reference ticks per sample
	output reg              os_tick   // 16x sample enable
);
	reg  [31:0]      acc;
	reg              ref_tick;
	reg  [PRE_W-1:0] cnt;
	wire [32:0]      sum = {1'b0, acc} + {1'b0, inc};

	// Fractional accumulator recreates the reference crystal rate
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			acc <= 32'h0000_0000;
			ref_tick <= 1'b0;
			cnt <= {PRE_W{1'b0}};
			os_tick <= 1'b0;
		end else begin
			acc <= sum[31:0];
			ref_tick <= sum[32];
			os_tick <= 1'b0;
			if (ref_tick) begin
				if (cnt >= prescale - 1'b1) begin
					cnt <= {PRE_W{1'b0}};
					os_tick <= 1'b1;
				end else begin
					cnt <= cnt + 1'b1;
				end
			end
		end
	end
endmodule // serial_tick_gen

// ### serial_rx.v
`timescale 1ns/100ps
module serial_rx (
	input  wire       clock,   // System clock
	input  wire       rst_n,   // Async reset
	input  wire       os_tick, // 16x sample enable
	input  wire       rxd,     // Serial input
	input  wire       data7,   // Seven data bits
	output reg  [7:0] rx_data, // Received byte
	output reg        rx_stb   // One-cycle byte strobe
);
	reg       busy;
	reg [3:0] os;
	reg [3:0] bitn;
	reg [7:0] sh;
	wire [3:0] stop_idx = data7 ? 4'h8 : 4'h9;

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			os <= 4'h0;
			bitn <= 4'h0;
			sh <= 8'h00;
			rx_data <= 8'h00;
			rx_stb <= 1'b0;
		end else begin
			rx_stb <= 1'b0;
			if (!busy) begin
				if (os_tick && !rxd) begin
					busy <= 1'b1;
					os <= 4'h0;
					bitn <= 4'h0;
				end
			end else if (os_tick) begin
				os <= os + 4'h1;
				if (os == 4'h7) begin
					bitn <= bitn + 4'h1;
					// Glitch on start bit is not a frame
					if (bitn == 4'h0) begin
						if (rxd)
							busy <= 1'b0;
					end else if (bitn == stop_idx) begin
						busy <= 1'b0;
						rx_stb <= rxd;
						rx_data <= data7 ? {1'b0, sh[7:1]} : sh;
					end else begin
						sh <= {rxd, sh[7:1]};
					end
				end
			end
		end
	end
endmodule // serial_rx

// ### serial_port_engine.v
`timescale 1ns/100ps
`include "serial_map.vh"
module serial_port_engine #(
	parameter        SLOW_REF   = 0,            // Slower reference variant
	parameter        BUF_AW     = 12,           // Buffer address width
	parameter [12:0] BUF_LIMIT  = 13'h0FFE,     // Usable buffer bytes
	parameter [12:0] RTS_MARGIN = 13'h0010,     // Headroom below limit
	parameter [31:0] TICK_CYC   = `TICK_CYCLES  // Cycles per delay tick
) (
	input  wire        clock,         // 100 MHz clock
	input  wire        rst_n,         // Async reset
	input  wire [7:0]  awaddr,        // AXI write address
	input  wire        awvalid,       // AXI write address valid
	output wire        awready,       // AXI write address ready
	input  wire [31:0] wdata,         // AXI write data
	input  wire [3:0]  wstrb,         // AXI write strobes
	input  wire        wvalid,        // AXI write data valid
	output wire        wready,        // AXI write data ready
	output reg  [1:0]  bresp,         // AXI write response
	output reg         bvalid,        // AXI write response valid
	input  wire        bready,        // AXI write response ready
	input  wire [7:0]  araddr,        // AXI read address
	input  wire        arvalid,       // AXI read address valid
	output wire        arready,       // AXI read address ready
	output reg  [31:0] rdata,         // AXI read data
	output reg  [1:0]  rresp,         // AXI read response
	output reg         rvalid,        // AXI read valid
	input  wire        rready,        // AXI read ready
	input  wire        rxd,           // Serial in from terminal
	output wire        txd,           // Serial out to terminal
	output reg         rts,           // RTS line
	output reg         dtr,           // DTR line
	input  wire        cts,           // CTS line
	input  wire        current_loop,  // 20 mA interface fitted
	input  wire        net_connected, // Network connection open
	input  wire [7:0]  net_tx_data,   // Byte toward serial
	input  wire        net_tx_valid,  // Byte toward serial valid
	output wire        net_tx_ready,  // Byte toward serial taken
	output wire [7:0]  net_rx_data,   // Packed byte toward network
	output wire        net_rx_valid,  // Packed byte valid
	output wire        net_rx_last,   // Last byte of packet
	input  wire        net_rx_ready,  // Network takes byte
	output reg         session_close, // Close management session
	output reg         soft_reset     // Software reset request
);
	localparam [12:0] HI_LEVEL = BUF_LIMIT - RTS_MARGIN;
	localparam [12:0] LO_LEVEL = BUF_LIMIT >> 1;
	localparam [15:0] DIV_RST = SLOW_REF ? `DIV_RST_S : `DIV_RST_F;
	localparam [63:0] INC_W = SLOW_REF ? `INC_SLOW : `INC_FAST;
	localparam [31:0] INC = INC_W[31:0];

	// Shadow (written) and active (saved) settings
	reg  [4:0]  sh_cfg, act_cfg;
	reg  [15:0] sh_div, act_div;
	reg  [8:0]  sh_spc, act_spc;
	reg  [15:0] sh_dly, act_dly;
	reg         aw_ok, w_ok;
	reg  [7:0]  aw_a;
	reg  [31:0] w_d;
	reg  [3:0]  w_s;
	reg         buf_clr, conn_q;
	wire        wr_go = aw_ok & w_ok & ~bvalid;
	wire [31:0] m = {{8{w_s[3]}}, {8{w_s[2]}}, {8{w_s[1]}}, {8{w_s[0]}}};
	wire [31:0] nd = w_d & m;
	wire        wr_cfg = wr_go && aw_a == `A_CONFIG;
	wire        wr_div = wr_go && aw_a == `A_DIVISOR;
	wire        wr_spc = wr_go && aw_a == `A_SPECIAL;
	wire        wr_dly = wr_go && aw_a == `A_DELAY;
	wire        wr_cmd = wr_go && aw_a == `A_COMMAND;
	wire        do_save = wr_cmd & nd[`CMD_SAVE];
	wire        do_fac = wr_cmd & nd[`CMD_FACTORY];
	wire        wr_map = wr_cfg | wr_div | wr_spc | wr_dly | wr_cmd;

	assign awready = ~aw_ok & ~bvalid;
	assign wready = ~w_ok & ~bvalid;
	assign arready = ~rvalid;

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			aw_ok <= 1'b0;
			w_ok <= 1'b0;
			aw_a <= 8'h00;
			w_d <= 32'h0000_0000;
			w_s <= 4'h0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
		end else begin
			if (awvalid && awready) begin
				aw_ok <= 1'b1;
				aw_a <= awaddr;
			end
			if (wvalid && wready) begin
				w_ok <= 1'b1;
				w_d <= wdata;
				w_s <= wstrb;
			end
			if (wr_go) begin
				aw_ok <= 1'b0;
				w_ok <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_map ? 2'h0 : 2'h2;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sh_cfg <= `CFG_RESET;
			sh_div <= DIV_RST;
			sh_spc <= `SPC_RESET;
			sh_dly <= 16'h0000;
			act_cfg <= `CFG_RESET;
			act_div <= DIV_RST;
			act_spc <= `SPC_RESET;
			act_dly <= 16'h0000;
			session_close <= 1'b0;
			soft_reset <= 1'b0;
			buf_clr <= 1'b0;
			conn_q <= 1'b0;
		end else begin
			conn_q <= net_connected;
			session_close <= do_fac; // R14
			soft_reset <= session_close; // R14
			// Without the flush option buffered data rides over reconnects
			buf_clr <= do_save | do_fac |
				(net_connected & ~conn_q & act_cfg[`C_FLUSH]); // R11 R12 R13
			if (wr_cfg)
				sh_cfg <= (sh_cfg & ~m[4:0]) | nd[4:0];
			if (wr_div)
				sh_div <= (sh_div & ~m[15:0]) | nd[15:0];
			if (wr_spc)
				sh_spc <= (sh_spc & ~m[8:0]) | nd[8:0];
			if (wr_dly)
				sh_dly <= (sh_dly & ~m[15:0]) | nd[15:0];
			if (do_fac) begin
				sh_cfg <= `CFG_RESET; // R14
				sh_div <= DIV_RST;
				sh_spc <= `SPC_RESET;
				sh_dly <= 16'h0000;
				act_cfg <= `CFG_RESET;
				act_div <= DIV_RST;
				act_spc <= `SPC_RESET;
				act_dly <= 16'h0000;
			end else if (do_save) begin
				act_cfg <= sh_cfg; // R13
				act_div <= sh_div;
				act_spc <= sh_spc;
				act_dly <= sh_dly;
			end
		end
	end

	// Effective line functions per profile
	reg [1:0] rts_fn, dtr_fn;
	reg       cts_fl, xon_rx, xon_tx, filt_tx, filt_rx;
	always @* begin
		rts_fn = `FN_HIGH;
		dtr_fn = `FN_HIGH;
		cts_fl = 1'b0;
		xon_rx = 1'b0;
		xon_tx = 1'b0;
		filt_tx = 1'b0;
		filt_rx = 1'b0;
		case (act_cfg[`C_PROF_HI:`C_PROF_LO]) // R5
		`PROF_HW: begin
			rts_fn = `FN_FLOW; // R6
			dtr_fn = `FN_CONN; // R6
			cts_fl = 1'b1; // R6
		end
		`PROF_SW: begin
			xon_rx = 1'b1; // R7 R8
			xon_tx = 1'b1;
			filt_tx = 1'b1;
			filt_rx = 1'b1;
		end
		`PROF_SPC: begin
			rts_fn = act_spc[`S_RTS_LO+1:`S_RTS_LO];
			dtr_fn = act_spc[`S_DTR_LO+1:`S_DTR_LO];
			cts_fl = act_spc[`S_CTS_FLOW];
			xon_rx = act_spc[`S_XON_RX];
			xon_tx = act_spc[`S_XON_TX];
			filt_tx = act_spc[`S_FILT_TX]; // R9
			filt_rx = act_spc[`S_FILT_RX]; // R9
		end
		default: begin
			rts_fn = `FN_HIGH;
		end
		endcase
	end

	// Bit-rate prescale from divisor
	wire        data7 = act_cfg[`C_DATA7];
	wire        std230 = act_cfg[`C_STD230] & ~current_loop; // R3 R4
	wire [15:0] div_min = current_loop ? (SLOW_REF ? `DIV_LOOP_S : `DIV_LOOP_F) :
		(SLOW_REF ? `DIV_MIN_S : `DIV_MIN_F); // R1 R4
	wire [15:0] div_eff = (act_div < div_min) ? div_min : act_div;
	wire [17:0] pre_slow = std230 ? `STD230_PRE : {2'b00, div_eff} * `SLOW_MUL; // R2 R3
	wire [17:0] prescale = SLOW_REF ? pre_slow : {2'b00, div_eff}; // R1
	wire        os_tick;
	wire [7:0]  rx_byte;
	wire        rx_stb;

	serial_tick_gen #(.PRE_W(18)) u_tick (
		.clock    (clock),
		.rst_n    (rst_n),
		.inc      (INC),
		.prescale (prescale),
		.os_tick  (os_tick)
	);

	serial_rx u_rx (
		.clock   (clock),
		.rst_n   (rst_n),
		.os_tick (os_tick),
		.rxd     (rxd),
		.data7   (data7),
		.rx_data (rx_byte),
		.rx_stb  (rx_stb)
	);

	// Receive buffer and packing
	reg  [7:0]        mem [0:(1<<BUF_AW)-1];
	reg  [BUF_AW-1:0] wp, rp;
	reg  [12:0]       cnt, rel;
	reg  [31:0]       ms_cnt;
	reg  [15:0]       dticks;
	reg               armed, tx_pause, xoff_sent;
	wire [7:0]        cmask = data7 ? 8'h7F : 8'hFF;
	wire [7:0]        rx_m = rx_byte & cmask;
	wire              rx_xon = rx_m == `CH_XON; // R19
	wire              rx_xoff = rx_m == `CH_XOFF; // R19
	wire              push = rx_stb & ~(filt_rx & (rx_xon | rx_xoff)) &
		(cnt < BUF_LIMIT) & ~buf_clr; // R7 R9
	wire              pop = net_rx_valid & net_rx_ready;
	wire              expire = armed & (dticks >= act_dly); // R10
	wire              flush = (rel == 13'h0000) & (cnt != 13'h0000) &
		(expire | cnt >= BUF_LIMIT); // R18

	assign net_rx_valid = rel != 13'h0000;
	assign net_rx_last = rel == 13'h0001;
	assign net_rx_data = mem[rp];

	always @(posedge clock) begin
		if (push)
			mem[wp] <= rx_byte;
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wp <= {BUF_AW{1'b0}};
			rp <= {BUF_AW{1'b0}};
			cnt <= 13'h0000;
			rel <= 13'h0000;
			ms_cnt <= 32'h0000_0000;
			dticks <= 16'h0000;
			armed <= 1'b0;
		end else if (buf_clr) begin
			wp <= {BUF_AW{1'b0}}; // R11 R13
			rp <= {BUF_AW{1'b0}};
			cnt <= 13'h0000;
			rel <= 13'h0000;
			armed <= 1'b0;
		end else begin
			if (push)
				wp <= wp + 1'b1;
			if (pop)
				rp <= rp + 1'b1;
			cnt <= cnt + {12'h000, push} - {12'h000, pop};
			if (flush) begin
				rel <= cnt; // R18
				armed <= 1'b0;
			end else if (pop) begin
				rel <= rel - 13'h0001;
			end
			if (armed && !expire) begin
				if (ms_cnt >= TICK_CYC - 1) begin
					ms_cnt <= 32'h0000_0000;
					dticks <= dticks + 16'h0001; // R10
				end else begin
					ms_cnt <= ms_cnt + 32'h0000_0001;
				end
			end
			if (push) begin
				armed <= 1'b1; // R18
				ms_cnt <= 32'h0000_0000;
				dticks <= 16'h0000;
			end
		end
	end

	// Transmit path
	reg  [9:0] tx_sh;
	reg  [3:0] tx_bits, tx_os;
	wire       tx_idle = tx_bits == 4'h0;
	wire [7:0] tx_m = net_tx_data & cmask;
	wire       tx_drop = filt_tx & (tx_m == `CH_XON | tx_m == `CH_XOFF); // R7 R9 R19
	wire       need_xoff = xon_tx & ~xoff_sent & (cnt >= HI_LEVEL);
	wire       need_xon = xon_tx & xoff_sent & (cnt < LO_LEVEL);
	wire       ctrl_pend = need_xoff | need_xon;
	wire       tx_load = tx_idle & ~ctrl_pend & ~tx_pause & (~cts_fl | cts); // R16
	wire       tx_take = net_tx_valid & ~tx_drop & tx_load;
	wire [7:0] tx_byte = need_xoff ? `CH_XOFF : need_xon ? `CH_XON : net_tx_data;

	// Dropped control codes are swallowed even while output is held
	assign net_tx_ready = tx_drop | tx_load;
	assign txd = tx_sh[0];

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_sh <= 10'h3FF;
			tx_bits <= 4'h0;
			tx_os <= 4'h0;
			tx_pause <= 1'b0;
			xoff_sent <= 1'b0;
			rts <= 1'b1;
			dtr <= 1'b1;
		end else begin
			if (tx_idle && (ctrl_pend || tx_take)) begin
				tx_sh <= data7 ? {2'b11, tx_byte[6:0], 1'b0} : {1'b1, tx_byte, 1'b0};
				tx_bits <= data7 ? 4'h9 : 4'hA;
				tx_os <= 4'h0;
				if (need_xoff)
					xoff_sent <= 1'b1;
				else if (need_xon)
					xoff_sent <= 1'b0;
			end else if (!tx_idle && os_tick) begin
				tx_os <= tx_os + 4'h1;
				if (tx_os == 4'hF) begin
					tx_sh <= {1'b1, tx_sh[9:1]};
					tx_bits <= tx_bits - 4'h1;
				end
			end
			// An XOFF arriving in the clear cycle still pauses
			if (!xon_rx)
				tx_pause <= 1'b0;
			else if (rx_stb && rx_xoff)
				tx_pause <= 1'b1; // R7
			else if (buf_clr || (rx_stb && rx_xon))
				tx_pause <= 1'b0; // R7
			// XOFF launched in the clear cycle stays recorded, so XON follows
			if (!xon_tx || (buf_clr && !(tx_idle && need_xoff)))
				xoff_sent <= 1'b0;
			case (rts_fn)
			`FN_FLOW: rts <= cnt < HI_LEVEL; // R6 R15
			`FN_CONN: rts <= net_connected;
			`FN_HIGH: rts <= 1'b1; // R8
			default:  rts <= 1'b0;
			endcase
			case (dtr_fn)
			`FN_FLOW: dtr <= cnt < HI_LEVEL;
			`FN_CONN: dtr <= net_connected; // R6 R17
			`FN_HIGH: dtr <= 1'b1; // R8
			default:  dtr <= 1'b0;
			endcase
		end
	end

	// Register reads
	reg [31:0] rd_val;
	reg        rd_ok;
	always @* begin
		rd_ok = 1'b1;
		if (araddr == `A_CONFIG)
			rd_val = {27'h0, sh_cfg};
		else if (araddr == `A_DIVISOR)
			rd_val = {16'h0000, sh_div};
		else if (araddr == `A_SPECIAL)
			rd_val = {23'h0, sh_spc};
		else if (araddr == `A_DELAY)
			rd_val = {16'h0000, sh_dly};
		else if (araddr == `A_COMMAND)
			rd_val = 32'h0000_0000;
		else if (araddr == `A_STATUS)
			rd_val = {12'h000, current_loop, cts, xoff_sent, tx_pause,
				net_connected, 2'b00, cnt};
		else begin
			rd_val = 32'h0000_0000;
			rd_ok = 1'b0;
		end
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= 2'h0;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= rd_val;
			rresp <= rd_ok ? 2'h0 : 2'h2;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end
endmodule // serial_port_engine

// ### serial_port_engine_checker.sv
`timescale 1ns/100ps
module serial_port_engine_checker (
	input wire        clock, rst_n, awready, wready, bvalid, bready, arvalid, arready, // AXI
	input wire        rvalid, rready, txd, net_tx_valid, net_tx_ready,                // Flow
	input wire        net_rx_valid, net_rx_ready, net_rx_last, session_close,         // Stream
	input wire        soft_reset,                                                      // Reset req
	input wire [1:0]  bresp,                                                           // Write resp
	input wire [31:0] rdata,                                                           // Read data
	input wire [7:0]  net_tx_data, net_rx_data                                         // Bytes
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_bresp_held: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("Write response dropped or changed early");
	a_busy_refuse: assert property (bvalid |-> !awready && !wready)
		else $error("New write accepted while response pending");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("Read answer not one cycle after address");
	a_rdata_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("Read data dropped or changed early");
	a_close_then_reset: assert property (session_close |=> soft_reset && !session_close)
		else $error("Software reset does not follow session close");
	a_reset_single: assert property (soft_reset |=> !soft_reset)
		else $error("Software reset longer than one cycle");
	a_start_bit: assert property (net_tx_valid && net_tx_ready && net_tx_data != 8'h11
		&& net_tx_data != 8'h13 |=> !txd)
		else $error("Start bit missing after byte accepted");
	a_packet_held: assert property (net_rx_valid && !net_rx_ready |=> net_rx_valid
		&& $stable(net_rx_data) && $stable(net_rx_last))
		else $error("Packet byte changed while stalled");
	a_last_valid: assert property (net_rx_last |-> net_rx_valid)
		else $error("Last marker without valid byte");
endmodule // serial_port_engine_checker

bind serial_port_engine serial_port_engine_checker chk_i (.clock(clock), .rst_n(rst_n),
	.awready(awready), .wready(wready), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
	.arready(arready), .rvalid(rvalid), .rready(rready), .txd(txd), .net_tx_valid(net_tx_valid),
	.net_tx_ready(net_tx_ready), .net_rx_valid(net_rx_valid), .net_rx_ready(net_rx_ready),
	.net_rx_last(net_rx_last), .session_close(session_close), .soft_reset(soft_reset),
	.bresp(bresp), .rdata(rdata), .net_tx_data(net_tx_data), .net_rx_data(net_rx_data));

// ### serial_term_model.sv
`timescale 1ns/100ps
module serial_term_model #(
	parameter real BIT_NS = 4340.28 // Divisor 3 on fast reference
) (
	input  wire       clock,    // System clock
	input  wire       txd,      // Line from engine
	output reg        rxd,      // Line to engine
	output reg  [7:0] got_data, // Decoded byte
	output reg        got_stb   // One-cycle byte strobe
);
	initial begin
		rxd = 1'b1;
		got_data = 8'h00;
		got_stb = 1'b0;
	end

	task send_byte(input [7:0] b);
		integer i;
		begin
			// Step off the sampling edge
			#1;
			rxd = 1'b0;
			#(BIT_NS);
			for (i = 0; i < 8; i = i + 1) begin
				rxd = b[i];
				#(BIT_NS);
			end
			rxd = 1'b1;
			#(BIT_NS);
		end
	endtask

	// Mid-bit sampling tolerates the accumulator jitter
	always begin : rx_loop
		reg [7:0] sh;
		integer   i;
		@(negedge txd);
		#(BIT_NS * 1.5);
		for (i = 0; i < 8; i = i + 1) begin
			sh[i] = txd;
			#(BIT_NS);
		end
		@(posedge clock);
		got_data <= sh;
		got_stb <= 1'b1;
		@(posedge clock);
		got_stb <= 1'b0;
	end
endmodule // serial_term_model

// ### serial_port_engine_tb.sv
`timescale 1ns/100ps
`include "serial_map.vh"
module serial_port_engine_tb;
	reg         clock, rst_n, awvalid, wvalid, bready, arvalid, rready;
	reg         cts, current_loop, net_connected, net_tx_valid, net_rx_ready;
	reg  [7:0]  awaddr, araddr, net_tx_data;
	reg  [31:0] wdata;
	reg  [3:0]  wstrb;
	wire        awready, wready, bvalid, arready, rvalid, txd, rxd, rts, dtr, got_stb;
	wire        net_tx_ready, net_rx_valid, net_rx_last, session_close, soft_reset;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	wire [7:0]  net_rx_data, got_data;
	integer     err_count, checked, seed;
	reg  [33:0] exp_rd[$];
	reg  [8:0]  exp_net[$];
	reg  [7:0]  exp_ser[$];

	serial_port_engine #(.TICK_CYC(32'h0000_0014)) DUT (.clock(clock), .rst_n(rst_n),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .rxd(rxd), .txd(txd), .rts(rts), .dtr(dtr), .cts(cts),
		.current_loop(current_loop), .net_connected(net_connected), .net_tx_data(net_tx_data),
		.net_tx_valid(net_tx_valid), .net_tx_ready(net_tx_ready), .net_rx_data(net_rx_data),
		.net_rx_valid(net_rx_valid), .net_rx_last(net_rx_last), .net_rx_ready(net_rx_ready),
		.session_close(session_close), .soft_reset(soft_reset));
	serial_term_model term (.clock(clock), .txd(txd), .rxd(rxd), .got_data(got_data),
		.got_stb(got_stb));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task final_report;
		begin
			// Expectations never met count as mismatches
			if (exp_rd.size() + exp_net.size() + exp_ser.size() != 0)
				err_count = err_count + 1;
			$display("Comparisons %0d, mismatches %0d", checked, err_count);
			if (err_count == 0 && checked > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask

	task chk(input [33:0] got, input [33:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask

	// Unexpected results compare against unknown and so always count
	always @(posedge clock) begin
		if (rvalid && rready)
			chk({rresp, rdata}, exp_rd.size() ? exp_rd.pop_front() : {34{1'bx}});
		if (net_rx_valid && net_rx_ready)
			chk({net_rx_last, net_rx_data}, exp_net.size() ? exp_net.pop_front() : 9'bx);
		if (got_stb)
			chk(got_data, exp_ser.size() ? exp_ser.pop_front() : 8'bx);
		net_rx_ready <= $random(seed);
	end

	task wr(input [7:0] a, input [31:0] d, input [1:0] eb);
		integer n;
		begin
			@(posedge clock);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			for (n = 0; n < 64; n = n + 1) begin
				@(posedge clock);
				if (awvalid && awready)
					awvalid <= 1'b0;
				if (wvalid && wready)
					wvalid <= 1'b0;
				if (bvalid) begin
					chk(bresp, eb);
					bready <= 1'b0;
					n = 64;
				end
			end
			if (n == 64)
				chk(34'h0_0000_0000, 34'h0_0000_0001);
		end
	endtask

	task rd(input [7:0] a, input [33:0] e);
		integer n;
		begin
			@(posedge clock);
			exp_rd.push_back(e);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			for (n = 0; n < 64; n = n + 1) begin
				@(posedge clock);
				if (arvalid && arready)
					arvalid <= 1'b0;
				if (rvalid) begin
					rready <= 1'b0;
					n = 64;
				end
			end
		end
	endtask

	task nt(input [7:0] b);
		integer n;
		begin
			@(posedge clock);
			net_tx_data <= b;
			net_tx_valid <= 1'b1;
			for (n = 0; n < 6000; n = n + 1) begin
				@(posedge clock);
				if (net_tx_ready) begin
					net_tx_valid <= 1'b0;
					n = 6000;
				end
			end
		end
	endtask

	// Save lands two cycles after the write edge
	task cfg(input [31:0] c);
		begin
			wr(`A_CONFIG, c, 2'h0);
			wr(`A_COMMAND, 32'h0000_0001, 2'h0);
			repeat (4) @(posedge clock);
		end
	endtask

	initial begin
		#1_000_000;
		err_count = err_count + 1;
		final_report;
	end

	initial begin
		seed = 85;
		err_count = 0;
		checked = 0;
		{rst_n, awvalid, wvalid, bready, arvalid, rready, net_tx_valid} = 7'h00;
		{awaddr, araddr, net_tx_data, wdata} = 56'h00_0000_0000_0000;
		{cts, current_loop, net_connected} = 3'h4;
		wstrb = 4'hF;
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		rd(`A_CONFIG, 34'h0_0000_0004);
		rd(`A_DIVISOR, 34'h0_0000_0048);
		rd(`A_SPECIAL, 34'h0_0000_0011);
		rd(`A_DELAY, 34'h0_0000_0000);
		rd(8'h40, 34'h2_0000_0000);
		wr(8'h40, 32'h0000_0001, 2'h2);
		wr(`A_DIVISOR, 32'h0000_0003, 2'h0);
		cfg(32'h0000_0005);
		chk(rts, 1'b1);
		chk(dtr, 1'b0);
		net_connected <= 1'b1;
		cts <= 1'b0;
		repeat (3) @(posedge clock);
		chk(dtr, 1'b1);
		exp_ser.push_back(8'h55);
		fork
			nt(8'h55);
			begin
				repeat (500) @(posedge clock);
				chk(txd, 1'b1);
				cts <= 1'b1;
			end
		join
		exp_net.push_back(9'h141);
		term.send_byte(8'h41);
		repeat (300) @(posedge clock);
		cfg(32'h0000_0006);
		cts <= 1'b0;
		chk({rts, dtr}, 2'h3);
		exp_ser.push_back(8'h62);
		nt(8'h11);
		nt(8'h62);
		exp_net.push_back(9'h143);
		term.send_byte(8'h11);
		term.send_byte(8'h43);
		repeat (300) @(posedge clock);
		wr(`A_SPECIAL, 32'h0000_000B, 2'h0);
		cfg(32'h0000_0007);
		chk({rts, dtr}, 2'h1);
		exp_ser.push_back(8'h13);
		nt(8'h13);
		exp_net.push_back(9'h111);
		term.send_byte(8'h11);
		repeat (5000) @(posedge clock);
		wstrb <= 4'h2;
		wr(`A_DELAY, 32'h0000_1264, 2'h0);
		wstrb <= 4'hF;
		rd(`A_DELAY, 34'h0_0000_1200);
		wr(`A_DELAY, 32'h0000_0064, 2'h0);
		cfg(32'h0000_0003);
		term.send_byte(8'h5A);
		net_connected <= 1'b0;
		repeat (3) @(posedge clock);
		net_connected <= 1'b1;
		repeat (1000) @(posedge clock);
		chk(net_rx_valid, 1'b0);
		exp_net.push_back(9'h15A);
		repeat (2000) @(posedge clock);
		cfg(32'h0000_0007);
		net_connected <= 1'b0;
		term.send_byte(8'h5B);
		rd(`A_STATUS, 34'h0_0000_0001);
		net_connected <= 1'b1;
		repeat (10) @(posedge clock);
		rd(`A_STATUS, 34'h0_0000_8000);
		current_loop <= 1'b1;
		wr(`A_COMMAND, 32'h0000_0002, 2'h0);
		repeat (5) @(posedge clock);
		rd(`A_CONFIG, 34'h0_0000_0004);
		rd(`A_DIVISOR, 34'h0_0000_0048);
		rd(`A_STATUS, 34'h0_0008_8000);
		repeat (20) @(posedge clock);
		final_report;
	end
endmodule // serial_port_engine_tb
